// [shared/usr_pkg.sv]
// Shared constants and types for the USB suspend/resume control block
package usr_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 125;
    localparam int IDLE_US = 3000;
    localparam int IDLE_CYC = IDLE_US * CLK_MHZ + 1;
    localparam int WAKE_US = 10;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int RESUME_US = 20;
    localparam int RESUME_CYC = RESUME_US * CLK_MHZ;
    localparam int RESET_US = 10;
    localparam int RESET_CYC = RESET_US * CLK_MHZ;
    localparam int ACT_GAP_CYC = 1000;
    // Register offsets
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h20;
    localparam logic [7:0] OFS_EP_FLAGS = 8'h21;
    localparam logic [7:0] OFS_CLOCK_CTRL = 8'h22;
    localparam logic [7:0] OFS_ADDR_WAKE = 8'h23;
    localparam logic [7:0] OFS_EP_HALT = 8'h24;
    localparam logic [7:0] OFS_ENG_STATUS = 8'h25;
    localparam logic [7:0] OFS_FIFO_MISC = 8'h26;
    localparam logic [7:0] OFS_SETUP_IO = 8'h27;
    localparam logic [7:0] OFS_EP0_PORT = 8'h28;
    localparam logic [7:0] OFS_EP1_PORT = 8'h29;
    localparam logic [7:0] OFS_EP2_PORT = 8'h2a;
    localparam logic [7:0] OFS_INT_STATUS = 8'h30;
    localparam logic [7:0] OFS_INT_MASK = 8'h31;
    // Control/status and clock control bit positions
    localparam int B_IDLE = 0;
    localparam int B_WAKE = 1;
    localparam int B_BRST = 2;
    localparam int B_RESUME = 3;
    localparam int B_REG = 4;
    localparam int B_RST2CPU = 7;
    localparam int B_CLKGATE = 3;
    localparam int B_DEEP = 4;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] CTRL_WMASK = 8'h96;
    // Endpoints and buffer sizes
    localparam int EP_COUNT = 3;
    localparam int EP0_BYTES = 8;
    localparam int EP1_BYTES = 8;
    localparam int EP2_BYTES = 384;
    localparam int EP_IDX_W = 3;
    // Interrupt status bits
    localparam int I_BUS_IDLE_FLAG = 0;
    localparam int I_RESUME = 1;
    localparam int I_BRST = 2;
    localparam int I_W = 3;
    // Bus line state
    typedef enum logic [1:0] {LINE_IDLE, LINE_ACTIVE, LINE_RESUME, LINE_RESET} usr_line_t;
endpackage : usr_pkg

// [shared/usr_link_if.sv]
// Bus link between device and host ends
`timescale 1ns/1ps
`default_nettype none
interface usr_link_if;
    import usr_pkg::*;
    usr_line_t hostLine;
    logic devWake;
    modport device (input hostLine, output devWake);
    modport host (output hostLine, input devWake);
endinterface : usr_link_if
`default_nettype wire

// [hw/usr_device.sv]
// Device end: suspend, resume, wake-up and control/status registers
//
// Notes on behaviour
// - Idle over 3ms sets suspend, interrupt
// - Firmware clears clock gate on suspend
// - Firmware may set deep sleep bit
// - Host resume sets resume bit, interrupt
// - Firmware re-enables clock, clears deep sleep
// - Resume bit clears when suspend falls
// - Wake command sends wake pulse to host
// - Three endpoints: control, interrupt, isochronous
// - Buffers 8, 8 and 384 bytes
// - Registers at 20h to 2ah
// - Suspend bit read-only, rising edge interrupts
// - Bus reset bit set by engine, interrupts
// - Regulator enable bit, resets to zero
// - Bits 5 and 6 read zero
// - Bus reset may reset the CPU
// - Isochronous buffer port ignores firmware access
// - Clock gate bit, resets to zero
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module usr_device #(
    parameter int IDLE_CYCLES = usr_pkg::IDLE_CYC,
    parameter int WAKE_CYCLES = usr_pkg::WAKE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // System outputs
    output logic usbIrq,
    output logic regulatorOutEn,
    output logic cpuResetReq,
    output logic linkClockGate,
    output logic deepSleepBit,
    // Bus link
    usr_link_if.device link
);
    import usr_pkg::*;

    // Elaboration check: the counters need at least these counts
    if (IDLE_CYCLES < 2 || WAKE_CYCLES < 1) begin : g_bad_counts
        $error("usr_device: counts too small");
    end

    logic [7:0] ctrl_q;
    logic [7:0] clkCtrl_q;
    logic [7:0] epFlags_q, addrWake_q, halt_q, engStat_q, misc_q, setupIo_q;
    logic [7:0] ep0Buf_q [EP0_BYTES];
    logic [7:0] ep1Buf_q [EP1_BYTES];
    logic [EP_IDX_W-1:0] ep0Ptr_q, ep1Ptr_q;
    logic [I_W-1:0] intStat_q, intMask_q;
    logic [31:0] idleCnt_q, wakeCnt_q;
    logic suspended_q, waking_q, inReset_q;

    wire busActive = link.hostLine != LINE_IDLE;
    wire wr = regWr;
    wire wrCtrl = wr && regAddr == OFS_CTRL_STATUS;
    wire suspendRise = !suspended_q && !busActive && idleCnt_q == 32'(IDLE_CYCLES - 1);
    wire resumeSeen = suspended_q && link.hostLine == LINE_RESUME;
    wire resetRise = !inReset_q && link.hostLine == LINE_RESET;

    // Idle counter, running only while the line is idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleCnt_q <= 32'h0;
        end else if (busActive || suspended_q) begin
            idleCnt_q <= 32'h0;
        end else begin
            idleCnt_q <= idleCnt_q + 32'h1;
        end
    end

    // Suspend state: entered on long idle, left when the line goes active or into reset, held through resume
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            suspended_q <= 1'b0;
        end else if (suspendRise) begin
            suspended_q <= 1'b1;
        end else if (suspended_q && (link.hostLine == LINE_RESET)) begin
            suspended_q <= 1'b0;
        end else if (suspended_q && busActive && link.hostLine != LINE_RESUME) begin
            suspended_q <= 1'b0;
        end
    end

    // Bus reset tracking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inReset_q <= 1'b0;
        end else begin
            inReset_q <= link.hostLine == LINE_RESET;
        end
    end

    // Control/status register; engine bits follow line state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q[B_REG] <= regWdata[B_REG];
                ctrl_q[B_RST2CPU] <= regWdata[B_RST2CPU];
                ctrl_q[B_BRST] <= regWdata[B_BRST];
                // Wake only accepted while suspended and not already signalling
                ctrl_q[B_WAKE] <= regWdata[B_WAKE] && suspended_q && !waking_q;
            end else if (waking_q && wakeCnt_q == 32'h0) begin
                ctrl_q[B_WAKE] <= 1'b0;
            end
            if (resetRise) begin
                ctrl_q[B_BRST] <= 1'b1;
            end else if (link.hostLine != LINE_RESET && inReset_q) begin
                ctrl_q[B_BRST] <= 1'b0;
            end
            ctrl_q[B_IDLE] <= suspended_q || suspendRise;
            if (resumeSeen) begin
                ctrl_q[B_RESUME] <= 1'b1;
            end else if (!suspended_q) begin
                ctrl_q[B_RESUME] <= 1'b0;
            end
            ctrl_q[6:5] <= 2'h0;
        end
    end

    // Wake pulse timer toward host
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            waking_q <= 1'b0;
            wakeCnt_q <= 32'h0;
        end else if (wrCtrl && regWdata[B_WAKE] && suspended_q && !waking_q) begin
            waking_q <= 1'b1;
            wakeCnt_q <= 32'(WAKE_CYCLES - 1);
        end else if (waking_q && wakeCnt_q == 32'h0) begin
            waking_q <= 1'b0;
        end else if (waking_q) begin
            wakeCnt_q <= wakeCnt_q - 32'h1;
        end
    end

    // Clock control register: gate and deep sleep, firmware driven
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkCtrl_q <= 8'h00;
        end else if (wr && regAddr == OFS_CLOCK_CTRL) begin
            clkCtrl_q <= regWdata & 8'h7f;
        end
    end

    // Plain storage registers outside this block's behaviour
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            epFlags_q <= 8'h00;
            addrWake_q <= 8'h00;
            halt_q <= 8'h00;
            engStat_q <= 8'h00;
            misc_q <= 8'h00;
            setupIo_q <= 8'h00;
        end else if (wr) begin
            unique case (regAddr)
                OFS_EP_FLAGS: epFlags_q <= regWdata & 8'h07;
                OFS_ADDR_WAKE: addrWake_q <= regWdata;
                OFS_EP_HALT: halt_q <= regWdata & 8'h07;
                OFS_ENG_STATUS: engStat_q <= regWdata;
                OFS_FIFO_MISC: misc_q <= regWdata;
                OFS_SETUP_IO: setupIo_q <= regWdata;
                default: ;
            endcase
        end
    end

    // Endpoint 0 and 1 buffers behind a rolling port; endpoint 2 is hardware only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ep0Ptr_q <= '0;
            ep1Ptr_q <= '0;
        end else begin
            if ((wr || regRd) && regAddr == OFS_EP0_PORT) begin
                ep0Ptr_q <= ep0Ptr_q + 3'h1;
            end
            if ((wr || regRd) && regAddr == OFS_EP1_PORT) begin
                ep1Ptr_q <= ep1Ptr_q + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr && regAddr == OFS_EP0_PORT) begin
            ep0Buf_q[ep0Ptr_q] <= regWdata;
        end
        if (wr && regAddr == OFS_EP1_PORT) begin
            ep1Buf_q[ep1Ptr_q] <= regWdata;
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            intStat_q <= '0;
            intMask_q <= '0;
        end else begin
            if (wr && regAddr == OFS_INT_MASK) begin
                intMask_q <= regWdata[I_W-1:0];
            end
            intStat_q <= (intStat_q & ~((wr && regAddr == OFS_INT_STATUS) ?
                          regWdata[I_W-1:0] : 3'h0))
                       | {resetRise, resumeSeen && !ctrl_q[B_RESUME], suspendRise};
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                OFS_CTRL_STATUS: regRdata <= ctrl_q & 8'h9f;
                OFS_EP_FLAGS: regRdata <= epFlags_q;
                OFS_CLOCK_CTRL: regRdata <= clkCtrl_q;
                OFS_ADDR_WAKE: regRdata <= addrWake_q;
                OFS_EP_HALT: regRdata <= halt_q;
                OFS_ENG_STATUS: regRdata <= engStat_q;
                OFS_FIFO_MISC: regRdata <= misc_q;
                OFS_SETUP_IO: regRdata <= setupIo_q;
                OFS_EP0_PORT: regRdata <= ep0Buf_q[ep0Ptr_q];
                OFS_EP1_PORT: regRdata <= ep1Buf_q[ep1Ptr_q];
                OFS_INT_STATUS: regRdata <= {5'h0, intStat_q};
                OFS_INT_MASK: regRdata <= {5'h0, intMask_q};
                default: regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // Registered system outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            usbIrq <= 1'b0;
            regulatorOutEn <= 1'b0;
            cpuResetReq <= 1'b0;
            linkClockGate <= 1'b0;
            deepSleepBit <= 1'b0;
            link.devWake <= 1'b0;
        end else begin
            usbIrq <= |(intStat_q & intMask_q);
            regulatorOutEn <= ctrl_q[B_REG];
            cpuResetReq <= ctrl_q[B_RST2CPU] && link.hostLine == LINE_RESET;
            linkClockGate <= clkCtrl_q[B_CLKGATE];
            deepSleepBit <= clkCtrl_q[B_DEEP];
            link.devWake <= waking_q;
        end
    end
endmodule : usr_device
`default_nettype wire

// [hw/usr_host.sv]
// Host end: drives line state, answers device wake with resume
`timescale 1ns/1ps
`default_nettype none
module usr_host #(
    parameter int RESUME_CYCLES = usr_pkg::RESUME_CYC,
    parameter int RESET_CYCLES = usr_pkg::RESET_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // User requests
    input wire logic busActiveReq,
    input wire logic resumeReq,
    input wire logic resetReq,
    // Status
    output logic busy,
    output logic wakeSeen,
    // Bus link
    usr_link_if.host link
);
    import usr_pkg::*;

    // Elaboration check: the sequencer needs at least one cycle per state
    if (RESUME_CYCLES < 1 || RESET_CYCLES < 1) begin : g_bad_counts
        $error("usr_host: counts too small");
    end

    typedef enum logic [1:0] {H_RUN, H_RESUME, H_RESET} usr_hstate_t;
    usr_hstate_t state_q;
    logic [31:0] cnt_q;

    // Line sequencer; device wake answered with resume
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= H_RUN;
            cnt_q <= 32'h0;
        end else begin
            unique case (state_q)
                H_RUN: begin
                    if (resetReq) begin
                        state_q <= H_RESET;
                        cnt_q <= 32'(RESET_CYCLES - 1);
                    end else if (resumeReq || link.devWake) begin
                        state_q <= H_RESUME;
                        cnt_q <= 32'(RESUME_CYCLES - 1);
                    end
                end
                H_RESUME, H_RESET: begin
                    if (cnt_q == 32'h0) begin
                        state_q <= H_RUN;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
            endcase
        end
    end

    // Registered line and status outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.hostLine <= LINE_IDLE;
            busy <= 1'b0;
            wakeSeen <= 1'b0;
        end else begin
            unique case (state_q)
                H_RESUME: link.hostLine <= LINE_RESUME;
                H_RESET: link.hostLine <= LINE_RESET;
                default: link.hostLine <= busActiveReq ? LINE_ACTIVE : LINE_IDLE;
            endcase
            busy <= state_q != H_RUN;
            wakeSeen <= link.devWake;
        end
    end
endmodule : usr_host
`default_nettype wire

// [tb/usr_assertions.sv]
// Checker watching the link between both ends and the device register port
`timescale 1ns/1ps
`default_nettype none
module usr_assertions
    import usr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link
    input wire usr_pkg::usr_line_t hostLine,
    input wire logic devWake,
    input wire logic wakeSeen,
    // Register port and outputs
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic regulatorOutEn,
    input wire logic linkClockGate,
    input wire logic cpuResetReq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Wake pulse length is fixed so the host can time it
    property p_wake_len;
        $rose(devWake) |-> devWake [*4] ##1 !devWake;
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake pulse length wrong");
    property p_wake_answer;
        $rose(devWake) |-> ##[1:8] hostLine == LINE_RESUME;
    endproperty
    a_wake_answer: assert property (p_wake_answer) else $error("host did not resume");
    property p_wake_seen;
        devWake |=> wakeSeen;
    endproperty
    a_wake_seen: assert property (p_wake_seen) else $error("host missed wake");
    // A wake on a busy bus would corrupt traffic
    property p_wake_bus_idle_flag;
        $rose(devWake) |-> hostLine != LINE_ACTIVE;
    endproperty
    a_wake_bus_idle_flag: assert property (p_wake_bus_idle_flag) else $error("wake outside suspend");
    property p_cpu_rst;
        cpuResetReq |-> $past(hostLine) == LINE_RESET;
    endproperty
    a_cpu_rst: assert property (p_cpu_rst) else $error("cpu reset without bus reset");
    property p_reg_en;
        regWr && regAddr == OFS_CTRL_STATUS |=> ##1 regulatorOutEn == $past(regWdata[4], 2);
    endproperty
    a_reg_en: assert property (p_reg_en) else $error("regulator enable wrong");
    property p_clk_gate;
        regWr && regAddr == OFS_CLOCK_CTRL |=> ##1 linkClockGate == $past(regWdata[3], 2);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock gate wrong");
    property p_ep2_rd;
        regRd && regAddr == OFS_EP2_PORT |=> regRdata == 8'h00;
    endproperty
    a_ep2_rd: assert property (p_ep2_rd) else $error("isochronous port readable");
    property p_ctrl_zero;
        regRd && regAddr == OFS_CTRL_STATUS |=> regRdata[6:5] == 2'b00;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused bits set");
    property p_rd_quiet;
        !$past(regRd) |-> regRdata == 8'h00;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
    // Main scenarios reached
    c_wake: cover property ($rose(devWake));
    c_resume: cover property ($rose(hostLine == LINE_RESUME));
    c_cpu_rst: cover property (cpuResetReq);
endmodule : usr_assertions
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench joining the device and host ends
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import usr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic [7:0] rnd;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic rdSeen = 1'b0;
    logic busActiveReq = 1'b1;
    logic resumeReq = 1'b0;
    logic resetReq = 1'b0;
    logic usbIrq, regulatorOutEn, cpuResetReq, linkClockGate, deepSleepBit, busy, wakeSeen;
    logic [7:0] expQ[$];
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    usr_link_if link ();
    usr_device #(.IDLE_CYCLES(50), .WAKE_CYCLES(4)) usr_device_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .usbIrq(usbIrq),
        .regulatorOutEn(regulatorOutEn), .cpuResetReq(cpuResetReq),
        .linkClockGate(linkClockGate), .deepSleepBit(deepSleepBit), .link(link));
    usr_host #(.RESUME_CYCLES(8), .RESET_CYCLES(8)) usr_host_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .busActiveReq(busActiveReq), .resumeReq(resumeReq),
        .resetReq(resetReq), .busy(busy), .wakeSeen(wakeSeen), .link(link));
    usr_assertions usr_assertions_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .hostLine(link.hostLine), .devWake(link.devWake),
        .wakeSeen(wakeSeen), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .regulatorOutEn(regulatorOutEn),
        .linkClockGate(linkClockGate), .cpuResetReq(cpuResetReq));
    always #4 ref_clk = ~ref_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    // Expected data is noted at issue and compared two edges later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask : rd
    // Bounded wait for the host to start and finish a line sequence
    task automatic waitDone();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        while (busy === 1'b1 && n < 80) begin
            @(posedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
    endtask : waitDone
    task automatic busReset(input logic e);
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk);
        resetReq <= 1'b1;
        @(posedge ref_clk);
        resetReq <= 1'b0;
        repeat (20) begin
            @(posedge ref_clk);
            seen = seen | cpuResetReq;
        end
        check({7'h00, seen}, {7'h00, e});
    endtask : busReset
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // Read result monitor
    always @(posedge ref_clk) begin
        rdSeen <= regRd;
        if (rdSeen) check(regRdata, expQ.pop_front());
    end
    // Hang guard, the run needs about 400 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h59cc));
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL_STATUS, CTRL_RESET);
        rd(OFS_CLOCK_CTRL, 8'h00);
        rd(8'h3f, 8'h00);
        rnd = 8'($urandom());
        wr(OFS_CTRL_STATUS, rnd);
        // Output is two registers behind the write strobe
        repeat (2) @(posedge ref_clk);
        check({7'h00, regulatorOutEn}, {7'h00, rnd[4]});
        rd(OFS_CTRL_STATUS, rnd & 8'h94);
        wr(OFS_EP2_PORT, rnd);
        rd(OFS_EP2_PORT, 8'h00);
        // Endpoint 0 and 1 ports wrap after eight accesses
        for (int i = 0; i < 8; i++) begin
            wr(OFS_EP0_PORT, rnd + 8'(i));
            wr(OFS_EP1_PORT, ~rnd - 8'(i));
        end
        for (int i = 0; i < 8; i++) begin
            rd(OFS_EP0_PORT, rnd + 8'(i));
            rd(OFS_EP1_PORT, ~rnd - 8'(i));
        end
        wr(OFS_CTRL_STATUS, CTRL_RESET);
        wr(OFS_INT_MASK, 8'h07);
        wr(OFS_CTRL_STATUS, 8'h82);
        repeat (10) @(posedge ref_clk);
        check({7'h00, wakeSeen}, 8'h00);
        rd(OFS_CTRL_STATUS, CTRL_RESET);
        $display("register test done");
        // Pass 0 resumes from the host, pass 1 by the device wake command
        for (int i = 0; i < 2; i++) begin
            busActiveReq <= 1'b0;
            repeat (60) @(posedge ref_clk);
            rd(OFS_CTRL_STATUS, 8'h81);
            check({7'h00, usbIrq}, 8'h01);
            wr(OFS_INT_STATUS, 8'h07);
            wr(OFS_CLOCK_CTRL, 8'h10);
            repeat (2) @(posedge ref_clk);
            check({6'h00, deepSleepBit, linkClockGate}, 8'h02);
            if (i == 0) begin
                @(posedge ref_clk);
                resumeReq <= 1'b1;
                @(posedge ref_clk);
                resumeReq <= 1'b0;
            end else begin
                wr(OFS_CTRL_STATUS, 8'h82);
            end
            waitDone();
            rd(OFS_CTRL_STATUS, 8'h89);
            rd(OFS_INT_STATUS, 8'h02);
            wr(OFS_CLOCK_CTRL, 8'h08);
            repeat (2) @(posedge ref_clk);
            check({6'h00, deepSleepBit, linkClockGate}, 8'h01);
            busActiveReq <= 1'b1;
            repeat (4) @(posedge ref_clk);
            rd(OFS_CTRL_STATUS, CTRL_RESET);
            wr(OFS_INT_STATUS, 8'h07);
            $display("suspend and resume pass %0d done", i);
        end
        // Bus reset with the interrupt masked, then unmasked and cleared
        wr(OFS_INT_MASK, 8'h00);
        busReset(1'b1);
        rd(OFS_INT_STATUS, 8'h04);
        check({7'h00, usbIrq}, 8'h00);
        wr(OFS_INT_MASK, 8'h04);
        repeat (2) @(posedge ref_clk);
        check({7'h00, usbIrq}, 8'h01);
        wr(OFS_INT_STATUS, 8'h04);
        repeat (2) @(posedge ref_clk);
        check({7'h00, usbIrq}, 8'h00);
        wr(OFS_CTRL_STATUS, 8'h00);
        busReset(1'b0);
        rd(OFS_CTRL_STATUS, 8'h00);
        repeat (3) @(posedge ref_clk);
        $display("bus reset test done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
